// *** logic/tsl_map.svh ***
`ifndef TSL_MAP_SVH
`define TSL_MAP_SVH

// command opcodes
`define TSL_CMD_READ_TEMP 8'hAA
`define TSL_CMD_START_CONV 8'hEE
`define TSL_CMD_STOP_CONV 8'h22
`define TSL_CMD_WRITE_UPPER 8'h01
`define TSL_CMD_WRITE_LOWER 8'h02
`define TSL_CMD_READ_UPPER 8'hA1
`define TSL_CMD_READ_LOWER 8'hA2
`define TSL_CMD_WRITE_STATUS 8'h0C
`define TSL_CMD_READ_STATUS 8'hAC
`define TSL_CMD_READ_COUNTER 8'hA0
`define TSL_CMD_LOAD_COUNTER 8'h41

// status/configuration field positions
`define TSL_BIT_DONE 7
`define TSL_BIT_ONE 6
`define TSL_BIT_BUSY 5
`define TSL_BIT_HIGH 4
`define TSL_BIT_LOW 3
`define TSL_BIT_MODE 2
`define TSL_BIT_POL 1
`define TSL_BIT_SINGLE 0

// word widths
`define TSL_BYTE_BITS 4'd8
`define TSL_COUNT_BITS 4'd9

// reset values of volatile state
`define TSL_TEMP_RESET 8'hC9
`define TSL_COUNT_RESET 9'h000

// timing
`define TSL_CLK_HZ 40000000
`define TSL_NV_WRITE_MS 10
`define TSL_NV_WRITE_CYCLES ((`TSL_NV_WRITE_MS * `TSL_CLK_HZ) / 1000)

`endif

// *** logic/tsl_pkg.sv ***
package tsl_pkg;

   // nonvolatile configuration bits
   typedef struct packed {
      logic high_flag;
      logic low_flag;
      logic power_up_mode;
      logic output_polarity;
      logic single_conversion_select;
   } tsl_cfg_t;

   // image held in the nonvolatile store
   typedef struct packed {
      logic [7:0] upper_trip_point;
      logic [7:0] lower_trip_point;
      tsl_cfg_t cfg;
   } tsl_nv_t;

   // one finished conversion from the measuring datapath
   typedef struct packed {
      logic [7:0] temp;
      logic [8:0] remain;
      logic [8:0] slope;
   } tsl_conv_t;

   typedef enum logic [3:0] {
      TSL_ST_CMD = 4'b0001,
      TSL_ST_WDATA = 4'b0010,
      TSL_ST_RDATA = 4'b0100,
      TSL_ST_DONE = 4'b1000
   } tsl_state_t;

endpackage : tsl_pkg

// *** logic/tsl_thermostat_status.sv ***
// What this block does
// - temperature held as 8-bit two's complement whole degrees, sign in bit 7
// - trip points use the same signed 8-bit format as the temperature
// - read-counter returns the 9-bit count left when the gate ended
// - load-counter copies the 9-bit slope accumulator into the counter register
// - power-up mode 1 converts continuously and drives the pin as thermostat output
// - thermostat asserts above upper point, releases only below lower point
// - polarity bit 1 makes the thermostat output active high, 0 active low
// - high flag sets when temperature exceeds upper point, cleared by writing 0
// - low flag sets when temperature is below lower point, cleared by writing 0
// - flags work in both modes; a flag set by a conversion reaches the store only with the next write command's strobe
// - status layout: done, fixed 1, busy, high, low, mode, polarity, single
// - done bit reads 0 during a conversion and 1 once complete
// - busy bit reads 1 while a nonvolatile write is in progress
// - power-up mode bit 0 gives bus mode, 1 gives thermostat mode
// - single select 0: start begins continuous conversions, stop ends them
// - single select 1: start performs one conversion then returns to standby
// - flags, mode, polarity and single select live in nonvolatile storage
// - commands and data travel least significant bit first
// - in continuous conversion the done bit always reads 0
// - read-temperature returns the 8-bit value of the last conversion
`timescale 1ns/1ps
`include "tsl_map.svh"

module tsl_thermostat_status
   import tsl_pkg::*;
#(
   parameter int NV_WRITE_CYCLES = `TSL_NV_WRITE_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire tsl_nv_t nv_image_in,
   input wire logic frame_start,
   input wire logic slot_valid,
   input wire logic slot_is_read,
   input wire logic slot_wbit,
   input wire logic mode_escape,
   input wire logic conv_done,
   input wire tsl_conv_t conv_result,
   output logic slot_rbit,
   output logic conv_run,
   output logic nv_write,
   output tsl_nv_t nv_image_out,
   output logic dq_out,
   output logic dq_oe_n,
   output logic thermostat_mode
);

   // signed strict compare shared by thermostat and flag logic
   function automatic logic above(input logic [7:0] a, input logic [7:0] b);
      above = $signed(a) > $signed(b);
   endfunction : above

   function automatic logic below(input logic [7:0] a, input logic [7:0] b);
      below = $signed(a) < $signed(b);
   endfunction : below

   logic loaded;
   logic [7:0] temperature_value;
   logic [7:0] upper_trip_point;
   logic [7:0] lower_trip_point;
   tsl_cfg_t cfg;
   logic [8:0] counter_value;
   logic [8:0] slope_value;
   logic running;
   logic one_shot_busy;
   logic done_bit;
   logic eeprom_busy;
   logic [31:0] nv_timer;
   logic therm_active;

   tsl_state_t state;
   logic [7:0] cmd;
   logic [8:0] shreg;
   logic [3:0] bit_cnt;
   logic [3:0] rd_len;

   logic [7:0] status_value;
   logic [7:0] next_shreg;
   logic cmd_end;
   logic wdata_end;
   logic hi_event;
   logic lo_event;
   logic wr_upper;
   logic wr_lower;
   logic wr_status;
   logic start_cmd;
   logic stop_cmd;
   logic load_cmd;

   // power-up image is taken one clock after release, never under reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         loaded <= 1'b0;
      end else begin
         loaded <= 1'b1;
      end
   end

   // bit assembly, least significant bit first
   assign next_shreg = {slot_wbit, shreg[7:1]};
   assign cmd_end = (state == TSL_ST_CMD) && slot_valid && !slot_is_read &&
                    (bit_cnt == `TSL_BYTE_BITS - 4'd1);
   assign wdata_end = (state == TSL_ST_WDATA) && slot_valid && !slot_is_read &&
                      (bit_cnt == `TSL_BYTE_BITS - 4'd1);

   assign wr_upper = wdata_end && (cmd == `TSL_CMD_WRITE_UPPER);
   assign wr_lower = wdata_end && (cmd == `TSL_CMD_WRITE_LOWER);
   assign wr_status = wdata_end && (cmd == `TSL_CMD_WRITE_STATUS);
   assign start_cmd = cmd_end && (next_shreg == `TSL_CMD_START_CONV);
   assign stop_cmd = cmd_end && (next_shreg == `TSL_CMD_STOP_CONV);
   assign load_cmd = cmd_end && (next_shreg == `TSL_CMD_LOAD_COUNTER);

   assign hi_event = conv_done && above(conv_result.temp, upper_trip_point);
   assign lo_event = conv_done && below(conv_result.temp, lower_trip_point);

   // done reads 0 whenever conversions run without end
   always_comb begin
      status_value = 8'h00;
      status_value[`TSL_BIT_DONE] = done_bit && cfg.single_conversion_select && !thermostat_mode;
      status_value[`TSL_BIT_ONE] = 1'b1;
      status_value[`TSL_BIT_BUSY] = eeprom_busy;
      status_value[`TSL_BIT_HIGH] = cfg.high_flag;
      status_value[`TSL_BIT_LOW] = cfg.low_flag;
      status_value[`TSL_BIT_MODE] = cfg.power_up_mode;
      status_value[`TSL_BIT_POL] = cfg.output_polarity;
      status_value[`TSL_BIT_SINGLE] = cfg.single_conversion_select;
   end

   // command and data sequencing
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= TSL_ST_CMD;
         cmd <= 8'h00;
         shreg <= 9'h000;
         bit_cnt <= 4'd0;
         rd_len <= 4'd0;
      end else if (frame_start || thermostat_mode) begin
         state <= TSL_ST_CMD;
         bit_cnt <= 4'd0;
         shreg <= 9'h000;
      end else begin
         case (state)
            TSL_ST_CMD: begin
               if (slot_valid && !slot_is_read) begin
                  shreg <= {1'b0, next_shreg};
                  bit_cnt <= bit_cnt + 4'd1;
                  if (cmd_end) begin
                     cmd <= next_shreg;
                     bit_cnt <= 4'd0;
                     rd_len <= `TSL_BYTE_BITS;
                     state <= TSL_ST_DONE;
                     case (next_shreg)
                        `TSL_CMD_WRITE_UPPER,
                        `TSL_CMD_WRITE_LOWER,
                        `TSL_CMD_WRITE_STATUS: begin
                           state <= TSL_ST_WDATA;
                        end
                        `TSL_CMD_READ_TEMP: begin
                           shreg <= {1'b0, temperature_value};
                           state <= TSL_ST_RDATA;
                        end
                        `TSL_CMD_READ_UPPER: begin
                           shreg <= {1'b0, upper_trip_point};
                           state <= TSL_ST_RDATA;
                        end
                        `TSL_CMD_READ_LOWER: begin
                           shreg <= {1'b0, lower_trip_point};
                           state <= TSL_ST_RDATA;
                        end
                        `TSL_CMD_READ_STATUS: begin
                           shreg <= {1'b0, status_value};
                           state <= TSL_ST_RDATA;
                        end
                        `TSL_CMD_READ_COUNTER: begin
                           shreg <= counter_value;
                           rd_len <= `TSL_COUNT_BITS;
                           state <= TSL_ST_RDATA;
                        end
                        default: begin
                           state <= TSL_ST_DONE;
                        end
                     endcase
                  end
               end
            end
            TSL_ST_WDATA: begin
               if (slot_valid && !slot_is_read) begin
                  shreg <= {1'b0, next_shreg};
                  bit_cnt <= bit_cnt + 4'd1;
                  if (wdata_end) begin
                     state <= TSL_ST_DONE;
                  end
               end
            end
            TSL_ST_RDATA: begin
               if (slot_valid && slot_is_read) begin
                  shreg <= {1'b0, shreg[8:1]};
                  bit_cnt <= bit_cnt + 4'd1;
                  if (bit_cnt == rd_len - 4'd1) begin
                     state <= TSL_ST_DONE;
                  end
               end
            end
            TSL_ST_DONE: begin
               state <= TSL_ST_DONE;
            end
            default: begin
               state <= TSL_ST_CMD;
            end
         endcase
      end
   end

   // read slot answers with the current low bit; past the end the line floats high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slot_rbit <= 1'b1;
      end else if (slot_valid && slot_is_read) begin
         slot_rbit <= (state == TSL_ST_RDATA) ? shreg[0] : 1'b1;
      end
   end

   // trip points, volatile copy of the nonvolatile store
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         upper_trip_point <= 8'h00;
         lower_trip_point <= 8'h00;
      end else if (!loaded) begin
         upper_trip_point <= nv_image_in.upper_trip_point;
         lower_trip_point <= nv_image_in.lower_trip_point;
      end else begin
         if (wr_upper) begin
            upper_trip_point <= next_shreg;
         end
         if (wr_lower) begin
            lower_trip_point <= next_shreg;
         end
      end
   end

   // configuration; a flag event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg <= '0;
      end else if (!loaded) begin
         cfg <= nv_image_in.cfg;
      end else begin
         if (wr_status) begin
            cfg.power_up_mode <= next_shreg[`TSL_BIT_MODE];
            cfg.output_polarity <= next_shreg[`TSL_BIT_POL];
            cfg.single_conversion_select <= next_shreg[`TSL_BIT_SINGLE];
         end
         cfg.high_flag <= hi_event || (wr_status ? next_shreg[`TSL_BIT_HIGH] : cfg.high_flag);
         cfg.low_flag <= lo_event || (wr_status ? next_shreg[`TSL_BIT_LOW] : cfg.low_flag);
      end
   end

   // operating mode: chosen by the stored mode bit, escape only swaps it for now
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         thermostat_mode <= 1'b0;
      end else if (!loaded) begin
         thermostat_mode <= nv_image_in.cfg.power_up_mode;
      end else if (mode_escape) begin
         thermostat_mode <= !thermostat_mode;
      end
   end

   // conversion control
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         running <= 1'b0;
         one_shot_busy <= 1'b0;
         done_bit <= 1'b0;
      end else if (thermostat_mode) begin
         running <= 1'b1;
         one_shot_busy <= 1'b0;
         done_bit <= 1'b0;
      end else if (start_cmd) begin
         if (cfg.single_conversion_select) begin
            one_shot_busy <= 1'b1;
            done_bit <= 1'b0;
         end else begin
            running <= 1'b1;
         end
      end else if (stop_cmd && !cfg.single_conversion_select) begin
         running <= 1'b0;
      end else if (conv_done && one_shot_busy) begin
         one_shot_busy <= 1'b0;
         done_bit <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conv_run <= 1'b0;
      end else begin
         conv_run <= running || one_shot_busy;
      end
   end

   // results of the last finished conversion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         temperature_value <= `TSL_TEMP_RESET;
         counter_value <= `TSL_COUNT_RESET;
         slope_value <= `TSL_COUNT_RESET;
      end else if (conv_done) begin
         temperature_value <= conv_result.temp;
         counter_value <= conv_result.remain;
         slope_value <= conv_result.slope;
      end else if (load_cmd) begin
         counter_value <= slope_value;
      end
   end

   // hysteresis between the two trip points
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         therm_active <= 1'b0;
      end else if (hi_event) begin
         therm_active <= 1'b1;
      end else if (lo_event) begin
         therm_active <= 1'b0;
      end
   end

   // open drain: pull low only in thermostat mode, when the present output level maps to a low pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dq_oe_n <= 1'b1;
         dq_out <= 1'b0;
      end else begin
         dq_oe_n <= !(thermostat_mode && (therm_active != cfg.output_polarity));
         dq_out <= 1'b0;
      end
   end

   // nonvolatile write: busy timer, a new write while busy is not checked
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nv_timer <= 32'h0000_0000;
         eeprom_busy <= 1'b0;
         nv_write <= 1'b0;
         nv_image_out <= '0;
      end else begin
         // image trails the registers by one cycle, so it settles one cycle after the strobe is seen
         nv_image_out.upper_trip_point <= upper_trip_point;
         nv_image_out.lower_trip_point <= lower_trip_point;
         nv_image_out.cfg <= cfg;
         nv_write <= wr_upper || wr_lower || wr_status;
         if (nv_write) begin
            nv_timer <= NV_WRITE_CYCLES[31:0];
            eeprom_busy <= 1'b1;
         end else if (nv_timer > 32'h0000_0001) begin
            nv_timer <= nv_timer - 32'h0000_0001;
         end else begin
            nv_timer <= 32'h0000_0000;
            eeprom_busy <= 1'b0;
         end
      end
   end

endmodule : tsl_thermostat_status

// *** dv/tsl_status_asserts.sv ***
`timescale 1ns/1ps
`include "tsl_map.svh"

module tsl_status_asserts
   import tsl_pkg::*;
#(
   parameter int NV_WRITE_CYCLES = `TSL_NV_WRITE_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire tsl_nv_t nv_image_in,
   input wire logic frame_start,
   input wire logic slot_valid,
   input wire logic slot_is_read,
   input wire logic slot_wbit,
   input wire logic mode_escape,
   input wire logic conv_done,
   input wire tsl_conv_t conv_result,
   input wire logic slot_rbit,
   input wire logic conv_run,
   input wire logic nv_write,
   input wire tsl_nv_t nv_image_out,
   input wire logic dq_out,
   input wire logic dq_oe_n,
   input wire logic thermostat_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // the pin lags the mode by a register, so allow settling
   pin_idle_a: assert property ((!thermostat_mode)[*3] |-> dq_oe_n)
      else $error("pin pulled in bus mode");
   pin_open_a: assert property (dq_out == 1'b0)
      else $error("pin driven high");
   mode_run_a: assert property ($rose(thermostat_mode) |-> ##[0:3] conv_run)
      else $error("no conversion in thermostat mode");
   trip_high_a: assert property (conv_done && thermostat_mode &&
      $signed(conv_result.temp) > $signed(nv_image_out.upper_trip_point)
      |-> ##2 (!thermostat_mode || dq_oe_n == nv_image_out.cfg.output_polarity))
      else $error("thermostat not active above upper point");
   trip_low_a: assert property (conv_done && thermostat_mode &&
      $signed(conv_result.temp) < $signed(nv_image_out.lower_trip_point)
      |-> ##2 (!thermostat_mode || dq_oe_n == !nv_image_out.cfg.output_polarity))
      else $error("thermostat not released below lower point");
   flag_high_a: assert property (conv_done &&
      $signed(conv_result.temp) > $signed(nv_image_out.upper_trip_point) |-> ##2 nv_image_out.cfg.high_flag)
      else $error("high flag not set");
   flag_low_a: assert property (conv_done &&
      $signed(conv_result.temp) < $signed(nv_image_out.lower_trip_point) |-> ##2 nv_image_out.cfg.low_flag)
      else $error("low flag not set");
   one_shot_a: assert property (conv_done && !thermostat_mode &&
      nv_image_out.cfg.single_conversion_select |-> ##[1:2] !conv_run)
      else $error("one-shot conversion kept running");
   nv_pulse_a: assert property (nv_write |=> !nv_write)
      else $error("store strobe longer than a cycle");
endmodule : tsl_status_asserts

bind tsl_thermostat_status tsl_status_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_chk (
   .clk(clk), .resetn(resetn), .nv_image_in(nv_image_in), .frame_start(frame_start),
   .slot_valid(slot_valid), .slot_is_read(slot_is_read), .slot_wbit(slot_wbit),
   .mode_escape(mode_escape), .conv_done(conv_done), .conv_result(conv_result),
   .slot_rbit(slot_rbit), .conv_run(conv_run), .nv_write(nv_write), .nv_image_out(nv_image_out),
   .dq_out(dq_out), .dq_oe_n(dq_oe_n), .thermostat_mode(thermostat_mode)
);

// *** dv/tsl_master_model.sv ***
`timescale 1ns/1ps

// sole master on the line: the device has no addressing
module tsl_master_model (
   input wire logic clk,
   input wire logic slot_rbit,
   output logic frame_start,
   output logic slot_valid,
   output logic slot_is_read,
   output logic slot_wbit
);
   initial begin
      frame_start = 1'b0;
      slot_valid = 1'b0;
      slot_is_read = 1'b0;
      slot_wbit = 1'b1;
   end

   // one frame: opcode, then n_wr written bits or n_rd read bits
   task automatic xfer(input logic [7:0] op, input logic [7:0] wd, input int n_wr, input int n_rd,
                       output logic [8:0] rd);
      rd = 9'h1ff;
      @(posedge clk);
      #1 frame_start = 1'b1;
      @(posedge clk);
      #1 frame_start = 1'b0;
      for (int i = 0; i < 8 + n_wr + n_rd; i++) begin
         slot_valid = 1'b1;
         slot_is_read = (i >= 8 + n_wr);
         slot_wbit = (i < 8) ? op[i] : (i < 8 + n_wr) ? wd[(i - 8) & 7] : 1'b1;
         @(posedge clk);
         #1;
         if (slot_is_read) begin
            slot_valid = 1'b0;
            @(posedge clk);
            #1 rd[i - 8 - n_wr] = slot_rbit;
         end
      end
      slot_valid = 1'b0;
      slot_is_read = 1'b0;
      // released line: show something other than the last bit
      slot_wbit = ~slot_wbit;
   endtask : xfer
endmodule : tsl_master_model

// *** dv/tsl_tb.sv ***
`timescale 1ns/1ps
`include "tsl_map.svh"

module tb;
   import tsl_pkg::*;
   // short store timer, but longer than one status read frame
   localparam int NVC = 60;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   tsl_nv_t nv_in;
   tsl_nv_t nv_out;
   tsl_conv_t conv;
   logic mode_escape, conv_done, frame_start, slot_valid, slot_is_read, slot_wbit;
   logic slot_rbit, conv_run, nv_write, dq_out, dq_oe_n, thermostat_mode;
   logic [8:0] rd;
   logic [8:0] remain;
   int fine16;
   int bad_count = 0;
   int checks_done = 0;

   always #12.5 clk = ~clk;

   tsl_thermostat_status #(.NV_WRITE_CYCLES(NVC)) i_dut (
      .clk(clk), .resetn(resetn), .nv_image_in(nv_in), .frame_start(frame_start),
      .slot_valid(slot_valid), .slot_is_read(slot_is_read), .slot_wbit(slot_wbit),
      .mode_escape(mode_escape), .conv_done(conv_done), .conv_result(conv), .slot_rbit(slot_rbit),
      .conv_run(conv_run), .nv_write(nv_write), .nv_image_out(nv_out), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .thermostat_mode(thermostat_mode)
   );

   tsl_master_model i_master (
      .clk(clk), .slot_rbit(slot_rbit), .frame_start(frame_start), .slot_valid(slot_valid),
      .slot_is_read(slot_is_read), .slot_wbit(slot_wbit)
   );

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic rd8(input logic [7:0] op, input logic [7:0] exp);
      i_master.xfer(op, 8'h00, 0, 8, rd);
      check({1'b0, rd[7:0]}, {1'b0, exp});
   endtask : rd8

   // waits out the store so no write overlaps another
   task automatic wr8(input logic [7:0] op, input logic [7:0] d);
      i_master.xfer(op, d, 8, 0, rd);
      repeat (NVC + 4) @(posedge clk);
   endtask : wr8

   task automatic cmd(input logic [7:0] op);
      i_master.xfer(op, 8'h00, 0, 0, rd);
      @(posedge clk);
      #1;
   endtask : cmd

   task automatic conv_in(input logic [7:0] t, input logic [8:0] r, input logic [8:0] s);
      @(posedge clk);
      #1 conv_done = 1'b1;
      conv = {t, r, s};
      @(posedge clk);
      #1 conv_done = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : conv_in

   task automatic esc;
      @(posedge clk);
      #1 mode_escape = 1'b1;
      @(posedge clk);
      #1 mode_escape = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask : esc

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   initial begin
      #(20000 * 25);
      bad_count++;
      close_out();
   end

   initial begin
      nv_in = {8'h19, 8'hE7, 5'b00000};
      mode_escape = 1'b0;
      conv_done = 1'b0;
      conv = '0;
      repeat (4) @(posedge clk);
      #1 resetn = 1'b1;
      check(dq_oe_n, 1'b1);
      rd8(`TSL_CMD_READ_UPPER, 8'h19);
      rd8(`TSL_CMD_READ_LOWER, 8'hE7);
      rd8(`TSL_CMD_READ_STATUS, 8'h40);
      conv_in(8'h7D, 9'h0A5, 9'h1F0);
      rd8(`TSL_CMD_READ_STATUS, 8'h50);
      rd8(`TSL_CMD_READ_TEMP, 8'h7D);
      i_master.xfer(`TSL_CMD_READ_COUNTER, 8'h00, 0, 9, rd);
      check(rd, 9'h0A5);
      remain = rd;
      cmd(`TSL_CMD_LOAD_COUNTER);
      i_master.xfer(`TSL_CMD_READ_COUNTER, 8'h00, 0, 9, rd);
      check(rd, 9'h1F0);
      // fine reading in sixteenths of a degree from the two counter reads
      fine16 = 16 * 125 - 8 + 16 * (int'(rd) - int'(remain)) / int'(rd);
      checks_done++;
      if (fine16 != 2002) begin
         bad_count++;
         $display("[ERR] %0t fine temperature %0d sixteenths", $time, fine16);
      end
      i_master.xfer(`TSL_CMD_WRITE_STATUS, 8'h00, 8, 0, rd);
      check(nv_write, 1'b1);
      rd8(`TSL_CMD_READ_STATUS, 8'h60);
      repeat (NVC) @(posedge clk);
      rd8(`TSL_CMD_READ_STATUS, 8'h40);
      conv_in(8'h19, 9'h000, 9'h000);
      rd8(`TSL_CMD_READ_STATUS, 8'h40);
      conv_in(8'hC9, 9'h000, 9'h000);
      rd8(`TSL_CMD_READ_TEMP, 8'hC9);
      rd8(`TSL_CMD_READ_STATUS, 8'h48);
      cmd(`TSL_CMD_START_CONV);
      check(conv_run, 1'b1);
      rd8(`TSL_CMD_READ_STATUS, 8'h48);
      cmd(`TSL_CMD_STOP_CONV);
      check(conv_run, 1'b0);
      wr8(`TSL_CMD_WRITE_STATUS, 8'h01);
      check(nv_out.cfg, 5'b00001);
      cmd(`TSL_CMD_START_CONV);
      check(conv_run, 1'b1);
      rd8(`TSL_CMD_READ_STATUS, 8'h41);
      conv_in(8'h00, 9'h000, 9'h000);
      check(conv_run, 1'b0);
      rd8(`TSL_CMD_READ_STATUS, 8'hC1);
      // trip points and polarity only change while in bus mode
      wr8(`TSL_CMD_WRITE_UPPER, 8'h55);
      wr8(`TSL_CMD_WRITE_LOWER, 8'hE2);
      rd8(`TSL_CMD_READ_UPPER, 8'h55);
      rd8(`TSL_CMD_READ_LOWER, 8'hE2);
      wr8(`TSL_CMD_WRITE_STATUS, 8'h02);
      esc();
      check(thermostat_mode, 1'b1);
      check(conv_run, 1'b1);
      conv_in(8'h7D, 9'h000, 9'h000);
      check(dq_oe_n, 1'b1);
      conv_in(8'h00, 9'h000, 9'h000);
      check(dq_oe_n, 1'b1);
      conv_in(8'hE0, 9'h000, 9'h000);
      check(dq_oe_n, 1'b0);
      esc();
      rd8(`TSL_CMD_READ_STATUS, 8'h5A);
      wr8(`TSL_CMD_WRITE_STATUS, 8'h00);
      esc();
      conv_in(8'hE0, 9'h000, 9'h000);
      check(dq_oe_n, 1'b1);
      conv_in(8'h7D, 9'h000, 9'h000);
      check(dq_oe_n, 1'b0);
      esc();
      // power cycle with thermostat mode held in the store
      resetn = 1'b0;
      nv_in = {8'h19, 8'hE7, 5'b00100};
      repeat (4) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clk);
      #1 check(thermostat_mode, 1'b1);
      check(conv_run, 1'b1);
      close_out();
   end
endmodule : tb
